// File: core/mdm_cfg.svh
`ifndef MDM_CFG_SVH
`define MDM_CFG_SVH

// ----------------------------------------------------------------
// holding register addresses, zero based as carried in a message
// ----------------------------------------------------------------
`define MDM_REG_LAST_ERR  16'h0007
`define MDM_REG_INDEX     16'h0009
`define MDM_REG_CMD       16'hc350
`define MDM_REG_REF       16'hc35a
`define MDM_REG_STATE     16'hc418
`define MDM_REG_ACTUAL    16'hc422
`define MDM_PAR_FIRST     16'h000a
`define MDM_PAR_LAST      16'hc34f

// ----------------------------------------------------------------
// coil addresses and command word fields
// ----------------------------------------------------------------
`define MDM_COIL_CMD      16'h0000
`define MDM_COIL_REF      16'h0010
`define MDM_COIL_STATE    16'h0020
`define MDM_COIL_ACTUAL   16'h0030
`define MDM_COIL_STORE    16'h0040
`define MDM_CMD_DC_BRAKE  4'h2
`define MDM_CMD_COAST     4'h3
`define MDM_CMD_QSTOP     4'h4
`define MDM_CMD_FREEZE    4'h5
`define MDM_CMD_START     4'h6
`define MDM_STW_USED_MASK 16'hef8f
`define MDM_COIL_ON       16'hff00
`define MDM_COIL_OFF      16'h0000

// ----------------------------------------------------------------
// exception codes and reset values
// ----------------------------------------------------------------
`define MDM_EXC_NONE      8'h00
`define MDM_EXC_ILL_FUNC  8'h01
`define MDM_EXC_ILL_ADDR  8'h02
`define MDM_EXC_ILL_VALUE 8'h03
`define MDM_EXC_FLAG      8'h80
`define MDM_CMD_RST       16'h0000
`define MDM_REF_RST       16'h0000
`define MDM_INDEX_RST     16'h0000
`define MDM_ERR_RST       16'h0000

`endif

// File: core/mdm_pkg.sv
package mdm_pkg;

	typedef enum logic [7:0]
	{
		MDM_FN_RD_COIL   = 8'h01,
		MDM_FN_RD_REG    = 8'h03,
		MDM_FN_WR_COIL   = 8'h05,
		MDM_FN_WR_REG    = 8'h06,
		MDM_FN_DIAG      = 8'h08,
		MDM_FN_EVENT     = 8'h0b,
		MDM_FN_WR_MCOIL  = 8'h0f,
		MDM_FN_WR_MREG   = 8'h10,
		MDM_FN_SLAVE_ID  = 8'h11
	} mdm_func_t;

	typedef enum logic [15:0]
	{
		MDM_SUB_RESTART  = 16'h0001,
		MDM_SUB_DIAG_REG = 16'h0002,
		MDM_SUB_CLEAR    = 16'h000a,
		MDM_SUB_BUS_MSG  = 16'h000b,
		MDM_SUB_BUS_ERR  = 16'h000c,
		MDM_SUB_EXC_ERR  = 16'h000d,
		MDM_SUB_SLV_MSG  = 16'h000e
	} mdm_sub_t;

	typedef enum logic [2:0]
	{
		MDM_ST_IDLE     = 3'b000,
		MDM_ST_CHECK    = 3'b001,
		MDM_ST_EXEC     = 3'b010,
		MDM_ST_WAIT_PAR = 3'b011
	} mdm_state_t;

endpackage

// File: core/mdm_counter.sv
module mdm_counter
	#(
	parameter int W = 16
	)
	(
	input  wire logic         clock_i,
	input  wire logic         rst_i,
	input  wire logic         clr_i,
	input  wire logic         inc_i,
	output logic [W-1:0]      cnt_o
	);

	if (W < 2)
	begin : g_bad_width
		$error("mdm_counter width below 2");
	end

	// clear and count together leave one: the new event is kept
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			cnt_o <= '0;
		else if (clr_i)
			cnt_o <= {{(W-1){1'b0}}, inc_i};
		else
			cnt_o <= cnt_o + {{(W-1){1'b0}}, inc_i};
	end

endmodule // mdm_counter

// File: core/mdm_data_map.sv
// Function
// - message addresses are zero based, first item is address zero
// - coils are single bits, holding registers are 16-bit words
// - register class comes from the function code, no 4xxxx prefix
// - coils 1-16 form the command word written by the master
// - coils 3-6 low request brake, coast, quick stop, freeze; coil 7 starts
// - coils 17-32 carry the 16-bit speed reference from the master
// - coils 33-48 present the read-only drive state word
// - state word bits per table, coils 37-39 and 45 read zero
// - coils 49-64 return frequency open loop, feedback closed loop
// - coil 65 selects RAM only or RAM plus EEPROM parameter storage
// - register 7 returns the last data object error code
// - register 9 holds the array index used for indexed parameters
// - registers 10 to 49999 map onto drive parameters
// - command word at register 50000, bus reference at 50010
// - state word at register 50200, main actual value at 50210
// - accept function codes 1, 3, 5, 6, 8, 0f, 10, 0b and 11
// - diagnostics sub 1 restarts, sub 2 reads, sub 10 clears
// - count bus, error, exception and own messages, subs 11 to 14
// - exception echoes function with top bit set plus a code
// - unsupported function or unsuitable state answers exception 1
// - start and length outside implemented addresses answer exception 2
// - broadcast requests are acted on but never answered
`include "mdm_cfg.svh"

module mdm_data_map
	#(
	parameter logic [15:0] SLAVE_ID = 16'h00a5 // arbitrary identity value
	)
	(
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	input  wire logic        req_valid_i,
	input  wire logic        req_bcast_i,
	input  wire logic [7:0]  req_func_i,
	input  wire logic [15:0] req_addr_i,
	input  wire logic [15:0] req_qty_i,
	input  wire logic [15:0] req_sub_i,
	input  wire logic        wr_valid_i,
	input  wire logic [15:0] wr_data_i,
	input  wire logic        bus_msg_i,
	input  wire logic        frame_err_i,
	input  wire logic [15:0] drive_state_i,
	input  wire logic [15:0] out_freq_i,
	input  wire logic [15:0] feedback_i,
	input  wire logic        closed_loop_i,
	input  wire logic        obj_err_valid_i,
	input  wire logic [15:0] obj_err_code_i,
	input  wire logic        par_avail_i,
	input  wire logic        par_ack_i,
	input  wire logic [15:0] par_rdata_i,
	output logic             req_ready_o,
	output logic             wr_ready_o,
	output logic             rd_valid_o,
	output logic [15:0]      rd_data_o,
	output logic             rsp_done_o,
	output logic             rsp_send_o,
	output logic [7:0]       rsp_func_o,
	output logic [7:0]       rsp_exc_o,
	output logic [15:0]      drive_command_word_o,
	output logic [15:0]      bus_speed_reference_o,
	output logic             store_eeprom_o,
	output logic             dc_brake_req_o,
	output logic             coast_req_o,
	output logic             quick_stop_req_o,
	output logic             freeze_req_o,
	output logic             start_o,
	output logic             par_req_o,
	output logic             par_we_o,
	output logic [15:0]      par_num_o,
	output logic [15:0]      par_wdata_o,
	output logic [15:0]      par_index_o,
	output logic             comm_restart_o
	);
	import mdm_pkg::*;

	// ----------------------------------------------------------------
	// request state
	// ----------------------------------------------------------------
	mdm_state_t  state_r;
	mdm_state_t  state_nxt;
	logic [7:0]  func_r;
	logic        bcast_r;
	logic [15:0] sub_r;
	logic [15:0] addr_r;
	logic [15:0] qty_r;
	logic [15:0] cur_r;
	logic [15:0] left_r;
	logic [15:0] err_r;
	logic [15:0] diag_r;
	logic [15:0] cnt_bus;
	logic [15:0] cnt_err;
	logic [15:0] cnt_exc;
	logic [15:0] cnt_slv;
	logic [15:0] cnt_ev;
	logic        accept;
	logic        fn_reg;
	logic        fn_wr;
	logic        fn_multi;
	logic        go;
	logic        par_item;
	logic        step;
	logic        last;
	logic        fin;
	logic [7:0]  fin_exc;
	logic        fin_rd;
	logic [15:0] fin_val;
	logic        clr_cnt;
	logic        restart;
	logic        item_bit;
	logic [15:0] item_word;
	logic [15:0] state_word;
	logic [15:0] main_actual;
	logic [15:0] rd_word;

	function automatic logic is_par(input logic [15:0] a);
		return (a >= `MDM_PAR_FIRST) && (a <= `MDM_PAR_LAST);
	endfunction

	function automatic logic item_ok(input logic reg_c, input logic wr_c, input logic [15:0] a);
		logic ro;
		ro = (a == `MDM_REG_LAST_ERR) || (a == `MDM_REG_STATE) || (a == `MDM_REG_ACTUAL);
		if (!reg_c)
			return (a <= `MDM_COIL_STORE) && !(wr_c && a >= `MDM_COIL_STATE && a < `MDM_COIL_STORE);
		// parameter groups plus the fixed registers
		return is_par(a) || (a == `MDM_REG_INDEX) || (a == `MDM_REG_CMD)
			|| (a == `MDM_REG_REF) || (ro && !wr_c);
	endfunction

	assign accept   = req_valid_i && req_ready_o;
	assign fn_reg   = (func_r == MDM_FN_RD_REG) || (func_r == MDM_FN_WR_REG)
		|| (func_r == MDM_FN_WR_MREG);
	assign fn_wr    = (func_r == MDM_FN_WR_COIL) || (func_r == MDM_FN_WR_REG)
		|| (func_r == MDM_FN_WR_MCOIL) || (func_r == MDM_FN_WR_MREG);
	assign fn_multi = (func_r == MDM_FN_WR_MCOIL) || (func_r == MDM_FN_WR_MREG);
	assign go       = !fn_multi || (wr_valid_i && wr_ready_o);
	assign par_item = fn_reg && is_par(cur_r);
	assign last     = (left_r == 16'h0001);
	assign item_bit  = fn_multi ? wr_data_i[0] : (sub_r == `MDM_COIL_ON);
	assign item_word = fn_multi ? wr_data_i : sub_r;
	assign state_word  = drive_state_i & `MDM_STW_USED_MASK;
	// loop mode picks the actual value
	assign main_actual = closed_loop_i ? feedback_i : out_freq_i;

	// ----------------------------------------------------------------
	// dispatch
	// ----------------------------------------------------------------
	always_comb
	begin
		state_nxt = state_r;
		fin       = 1'b0;
		fin_exc   = `MDM_EXC_NONE;
		fin_rd    = 1'b0;
		fin_val   = 16'h0000;
		clr_cnt   = 1'b0;
		restart   = 1'b0;
		step      = 1'b0;
		unique case (state_r)
		MDM_ST_IDLE:
			if (accept)
			begin
				fin = 1'b1;
				unique case (req_func_i)
				MDM_FN_RD_COIL, MDM_FN_RD_REG, MDM_FN_WR_MCOIL, MDM_FN_WR_MREG:
					if (req_bcast_i && (req_func_i == MDM_FN_RD_COIL
						|| req_func_i == MDM_FN_RD_REG))
						fin = 1'b1;
					else if (req_qty_i == 16'h0000)
						fin_exc = `MDM_EXC_ILL_VALUE;
					else
					begin
						fin       = 1'b0;
						state_nxt = MDM_ST_CHECK;
					end
				MDM_FN_WR_COIL:
					if (req_sub_i != `MDM_COIL_ON && req_sub_i != `MDM_COIL_OFF)
						fin_exc = `MDM_EXC_ILL_VALUE;
					else
					begin
						fin       = 1'b0;
						state_nxt = MDM_ST_CHECK;
					end
				MDM_FN_WR_REG:
				begin
					fin       = 1'b0;
					state_nxt = MDM_ST_CHECK;
				end
				MDM_FN_DIAG:
				begin
					fin_rd = 1'b1;
					unique case (req_sub_i)
					MDM_SUB_RESTART:  restart = 1'b1;
					MDM_SUB_DIAG_REG: fin_val = diag_r;
					MDM_SUB_CLEAR:    clr_cnt = 1'b1;
					MDM_SUB_BUS_MSG:  fin_val = cnt_bus;
					MDM_SUB_BUS_ERR:  fin_val = cnt_err;
					MDM_SUB_EXC_ERR:  fin_val = cnt_exc;
					MDM_SUB_SLV_MSG:  fin_val = cnt_slv;
					default:
					begin
						fin_rd  = 1'b0;
						fin_exc = `MDM_EXC_ILL_FUNC;
					end
					endcase
				end
				MDM_FN_EVENT:
				begin
					fin_rd  = 1'b1;
					fin_val = cnt_ev;
				end
				MDM_FN_SLAVE_ID:
				begin
					fin_rd  = 1'b1;
					fin_val = SLAVE_ID;
				end
				default: fin_exc = `MDM_EXC_ILL_FUNC;
				endcase
			end
		MDM_ST_CHECK:
			// whole range checked before any effect
			if (!item_ok(fn_reg, fn_wr, cur_r))
			begin
				fin       = 1'b1;
				fin_exc   = `MDM_EXC_ILL_ADDR;
				state_nxt = MDM_ST_IDLE;
			end
			else if (par_item && !par_avail_i)
			begin
				fin       = 1'b1;
				fin_exc   = `MDM_EXC_ILL_FUNC;
				state_nxt = MDM_ST_IDLE;
			end
			else if (last)
				state_nxt = MDM_ST_EXEC;
		MDM_ST_EXEC:
			if (go && par_item)
				state_nxt = MDM_ST_WAIT_PAR;
			else if (go)
			begin
				step = 1'b1;
				if (last)
				begin
					fin       = 1'b1;
					state_nxt = MDM_ST_IDLE;
				end
			end
		MDM_ST_WAIT_PAR:
			if (par_ack_i)
			begin
				step      = 1'b1;
				fin       = last;
				state_nxt = last ? MDM_ST_IDLE : MDM_ST_EXEC;
			end
		default: state_nxt = MDM_ST_IDLE;
		endcase
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			state_r     <= MDM_ST_IDLE;
			req_ready_o <= 1'b1;
			wr_ready_o  <= 1'b0;
			func_r      <= 8'h00;
			bcast_r     <= 1'b0;
			sub_r       <= 16'h0000;
			addr_r      <= 16'h0000;
			qty_r       <= 16'h0000;
			cur_r       <= 16'h0000;
			left_r      <= 16'h0000;
		end
		else
		begin
			state_r     <= state_nxt;
			req_ready_o <= (state_nxt == MDM_ST_IDLE);
			// multi-item writes pull one data word per item
			wr_ready_o  <= (state_nxt == MDM_ST_EXEC) && fn_multi;
			if (accept)
			begin
				func_r  <= req_func_i;
				bcast_r <= req_bcast_i;
				sub_r   <= req_sub_i;
				// address field used as item number directly
				addr_r  <= req_addr_i;
				cur_r   <= req_addr_i;
				if (req_func_i == MDM_FN_WR_COIL || req_func_i == MDM_FN_WR_REG)
				begin
					qty_r  <= 16'h0001;
					left_r <= 16'h0001;
				end
				else
				begin
					qty_r  <= req_qty_i;
					left_r <= req_qty_i;
				end
			end
			else if (state_r == MDM_ST_CHECK && state_nxt == MDM_ST_EXEC)
			begin
				cur_r  <= addr_r;
				left_r <= qty_r;
			end
			else if (state_r == MDM_ST_CHECK || step)
			begin
				cur_r  <= cur_r + 16'h0001;
				left_r <= left_r - 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// master-written data
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			drive_command_word_o  <= `MDM_CMD_RST;
			bus_speed_reference_o <= `MDM_REF_RST;
			par_index_o           <= `MDM_INDEX_RST;
			store_eeprom_o        <= 1'b0;
		end
		else if (step && fn_wr && state_r == MDM_ST_EXEC)
		begin
			// register or coil space follows the function code
			if (fn_reg)
			begin
				if (cur_r == `MDM_REG_INDEX)
					par_index_o <= item_word;
				// command word and bus reference registers
				if (cur_r == `MDM_REG_CMD)
					drive_command_word_o <= item_word;
				if (cur_r == `MDM_REG_REF)
					bus_speed_reference_o <= item_word;
			end
			// coils 1-16 into the command word
			else if (cur_r < `MDM_COIL_REF)
				drive_command_word_o[cur_r[3:0]] <= item_bit;
			else if (cur_r < `MDM_COIL_STATE)
				bus_speed_reference_o[cur_r[3:0]] <= item_bit;
			else if (cur_r == `MDM_COIL_STORE)
				store_eeprom_o <= item_bit;
		end
	end

	// one cycle behind the command word, so every output stays a flop
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			dc_brake_req_o   <= 1'b1;
			coast_req_o      <= 1'b1;
			quick_stop_req_o <= 1'b1;
			freeze_req_o     <= 1'b1;
			start_o          <= 1'b0;
		end
		else
		begin
			// active-low stop requests, start at one
			dc_brake_req_o   <= !drive_command_word_o[`MDM_CMD_DC_BRAKE];
			coast_req_o      <= !drive_command_word_o[`MDM_CMD_COAST];
			quick_stop_req_o <= !drive_command_word_o[`MDM_CMD_QSTOP];
			freeze_req_o     <= !drive_command_word_o[`MDM_CMD_FREEZE];
			start_o          <= drive_command_word_o[`MDM_CMD_START];
		end
	end

	// ----------------------------------------------------------------
	// parameter access and drive-side status
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			par_req_o   <= 1'b0;
			par_we_o    <= 1'b0;
			par_num_o   <= 16'h0000;
			par_wdata_o <= 16'h0000;
		end
		// parameter item handed to the drive
		else if (state_r == MDM_ST_EXEC && go && par_item)
		begin
			par_req_o   <= 1'b1;
			par_we_o    <= fn_wr;
			par_num_o   <= cur_r;
			par_wdata_o <= item_word;
		end
		else if (par_ack_i)
			par_req_o <= 1'b0;
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			err_r <= `MDM_ERR_RST;
		else if (obj_err_valid_i)
			err_r <= obj_err_code_i;
	end

	// a framing error in the clearing cycle stays recorded
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			diag_r <= 16'h0000;
		else if (clr_cnt)
			diag_r <= {15'h0000, frame_err_i};
		else
			diag_r <= diag_r | {15'h0000, frame_err_i};
	end

	mdm_counter #(.W(16)) u_cnt_bus (.clock_i(clock_i), .rst_i(rst_i), .clr_i(clr_cnt),
		.inc_i(bus_msg_i), .cnt_o(cnt_bus));
	mdm_counter #(.W(16)) u_cnt_err (.clock_i(clock_i), .rst_i(rst_i), .clr_i(clr_cnt),
		.inc_i(frame_err_i), .cnt_o(cnt_err));
	mdm_counter #(.W(16)) u_cnt_exc (.clock_i(clock_i), .rst_i(rst_i), .clr_i(clr_cnt),
		.inc_i(fin && fin_exc != `MDM_EXC_NONE), .cnt_o(cnt_exc));
	mdm_counter #(.W(16)) u_cnt_slv (.clock_i(clock_i), .rst_i(rst_i), .clr_i(clr_cnt),
		.inc_i(accept), .cnt_o(cnt_slv));
	mdm_counter #(.W(16)) u_cnt_ev (.clock_i(clock_i), .rst_i(rst_i), .clr_i(clr_cnt),
		.inc_i(fin && fin_exc == `MDM_EXC_NONE), .cnt_o(cnt_ev));

	// ----------------------------------------------------------------
	// answer
	// ----------------------------------------------------------------
	always_comb
	begin
		rd_word = 16'h0000;
		if (state_r == MDM_ST_WAIT_PAR)
			rd_word = par_rdata_i;
		else if (fn_reg)
		begin
			unique case (cur_r)
			`MDM_REG_LAST_ERR: rd_word = err_r;
			`MDM_REG_INDEX:    rd_word = par_index_o;
			`MDM_REG_CMD:      rd_word = drive_command_word_o;
			`MDM_REG_REF:      rd_word = bus_speed_reference_o;
			`MDM_REG_STATE:    rd_word = state_word;
			`MDM_REG_ACTUAL:   rd_word = main_actual;
			default:           rd_word = 16'h0000;
			endcase
		end
		else if (cur_r < `MDM_COIL_REF)
			rd_word = {15'h0000, drive_command_word_o[cur_r[3:0]]};
		else if (cur_r < `MDM_COIL_STATE)
			rd_word = {15'h0000, bus_speed_reference_o[cur_r[3:0]]};
		else if (cur_r < `MDM_COIL_ACTUAL)
			rd_word = {15'h0000, state_word[cur_r[3:0]]};
		else if (cur_r < `MDM_COIL_STORE)
			rd_word = {15'h0000, main_actual[cur_r[3:0]]};
		else
			rd_word = {15'h0000, store_eeprom_o};
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			rd_valid_o     <= 1'b0;
			rd_data_o      <= 16'h0000;
			rsp_done_o     <= 1'b0;
			rsp_send_o     <= 1'b0;
			rsp_func_o     <= 8'h00;
			rsp_exc_o      <= `MDM_EXC_NONE;
			comm_restart_o <= 1'b0;
		end
		else
		begin
			rd_valid_o     <= fin_rd || (step && !fn_wr);
			rd_data_o      <= fin_rd ? fin_val : rd_word;
			rsp_done_o     <= fin;
			comm_restart_o <= restart;
			rsp_send_o     <= fin && !(state_r == MDM_ST_IDLE ? req_bcast_i : bcast_r);
			if (fin)
			begin
				// exception flag on the echoed code
				rsp_func_o <= (state_r == MDM_ST_IDLE ? req_func_i : func_r)
					| ((fin_exc != `MDM_EXC_NONE) ? `MDM_EXC_FLAG : 8'h00);
				rsp_exc_o  <= fin_exc;
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	property p_exc_flag;
		rsp_done_o && rsp_exc_o != `MDM_EXC_NONE |-> rsp_func_o[7];
	endproperty
	a_exc_flag: assert property (p_exc_flag) else $error("exception without flag");

	property p_ill_func;
		accept && !(req_func_i inside {8'h01, 8'h03, 8'h05, 8'h06, 8'h08, 8'h0b, 8'h0f, 8'h10,
			8'h11}) |=> rsp_done_o && rsp_exc_o == `MDM_EXC_ILL_FUNC;
	endproperty
	a_ill_func: assert property (p_ill_func) else $error("bad function not refused");

	property p_bcast_quiet;
		rsp_done_o && bcast_r |-> !rsp_send_o;
	endproperty
	a_bcast_quiet: assert property (p_bcast_quiet) else $error("broadcast answered");

	property p_cmd_write;
		accept && req_func_i == MDM_FN_WR_REG && req_addr_i == `MDM_REG_CMD
		|-> ##3 drive_command_word_o == $past(req_sub_i, 3);
	endproperty
	a_cmd_write: assert property (p_cmd_write) else $error("command word not written");

	property p_index_write;
		accept && req_func_i == MDM_FN_WR_REG && req_addr_i == `MDM_REG_INDEX
		|-> ##3 par_index_o == $past(req_sub_i, 3);
	endproperty
	a_index_write: assert property (p_index_write) else $error("index not written");

	property p_start_coil;
		accept && req_func_i == MDM_FN_WR_COIL && req_addr_i == 16'h0006
		&& req_sub_i == `MDM_COIL_ON |-> ##4 start_o;
	endproperty
	a_start_coil: assert property (p_start_coil) else $error("start coil ignored");

	property p_state_read;
		accept && !req_bcast_i && req_func_i == MDM_FN_RD_REG
		&& req_addr_i == `MDM_REG_STATE && req_qty_i == 16'h0001
		|-> ##3 rd_valid_o && rd_data_o == ($past(drive_state_i) & `MDM_STW_USED_MASK);
	endproperty
	a_state_read: assert property (p_state_read) else $error("state word misread");

	property p_ro_refused;
		accept && req_func_i == MDM_FN_WR_REG && req_addr_i == `MDM_REG_STATE
		|-> ##2 rsp_done_o && rsp_exc_o == `MDM_EXC_ILL_ADDR;
	endproperty
	a_ro_refused: assert property (p_ro_refused) else $error("state write accepted");

	property p_coil_range;
		accept && !req_bcast_i && req_func_i == MDM_FN_RD_COIL && req_qty_i != 16'h0000
		&& req_addr_i > `MDM_COIL_STORE |-> ##2 rsp_done_o && rsp_exc_o == `MDM_EXC_ILL_ADDR;
	endproperty
	a_coil_range: assert property (p_coil_range) else $error("bad coil not refused");

	property p_exc_count;
		rsp_done_o && rsp_exc_o != `MDM_EXC_NONE |-> cnt_exc == $past(cnt_exc) + 16'h0001;
	endproperty
	a_exc_count: assert property (p_exc_count) else $error("exception not counted");

	property p_clear;
		accept && req_func_i == MDM_FN_DIAG && req_sub_i == MDM_SUB_CLEAR |=> cnt_exc == 16'h0000;
	endproperty
	a_clear: assert property (p_clear) else $error("counters not cleared");

endmodule // mdm_data_map

// File: bench/mdm_master.sv
module mdm_master
	(
	input  wire logic        clock_i,
	input  wire logic        rdy_i,
	input  wire logic        done_i,
	input  wire logic        send_i,
	input  wire logic        rdv_i,
	input  wire logic [15:0] rdd_i,
	input  wire logic        preq_i,
	input  wire logic [15:0] pnum_i,
	output logic             vld_o,
	output logic             bc_o,
	output logic [7:0]       fn_o,
	output logic [15:0]      ad_o,
	output logic [15:0]      qt_o,
	output logic [15:0]      sb_o,
	output logic             msg_o,
	output logic             pack_o,
	output logic [15:0]      prd_o
	);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		{vld_o, bc_o, fn_o, ad_o, qt_o, sb_o, msg_o, pack_o, prd_o} = '0;
	end

	// zero based address, class from function
	task automatic xfer(input logic b, input logic [7:0] f, input logic [15:0] a, q, s,
		output logic [15:0] d, output logic sn, dn);
		d = '0;
		sn = 1'b0;
		@(posedge clock_i);
		{vld_o, msg_o, bc_o, fn_o, ad_o, qt_o, sb_o} <= {2'b11, b, f, a, q, s};
		do @(posedge clock_i); while (!rdy_i);
		// released fields show garbage, not the last value
		{vld_o, msg_o, ad_o, qt_o, sb_o} <= {2'b00, ~a, ~q, ~s};
		for (int n = 0; n < 300 && !done_i; n++)
		begin
			@(posedge clock_i);
			if (rdv_i)
				d = rdd_i;
			if (done_i)
				sn = send_i;
		end
		dn = done_i;
	endtask

	// parameter store acks one cycle after a request
	always @(posedge clock_i)
	begin
		pack_o <= preq_i && !pack_o;
		prd_o  <= pnum_i ^ 16'h3c3c;
	end
endmodule // mdm_master

// File: bench/test_modbus_drive_data_map.sv
module test_modbus_drive_data_map;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
	$display("[ERR] %0t got %h exp %h", $time, a, b); end end

	logic clock_i, rst_i, req_valid_i, req_bcast_i, wr_valid_i, bus_msg_i, frame_err_i;
	logic closed_loop_i, obj_err_valid_i, par_avail_i, par_ack_i, req_ready_o, wr_ready_o;
	logic rd_valid_o, rsp_done_o, rsp_send_o, store_eeprom_o, dc_brake_req_o, coast_req_o;
	logic quick_stop_req_o, freeze_req_o, start_o, par_req_o, par_we_o, comm_restart_o, sn, dn;
	logic [7:0]  req_func_i, rsp_func_o, rsp_exc_o;
	logic [15:0] req_addr_i, req_qty_i, req_sub_i, wr_data_i, drive_state_i, out_freq_i;
	logic [15:0] feedback_i, obj_err_code_i, par_rdata_i, rd_data_o, drive_command_word_o;
	logic [15:0] bus_speed_reference_o, par_num_o, par_wdata_o, par_index_o, d, v;
	int          miscompares = 0;
	int          n_compared = 0;
	// function, address, value, expected echo and exception
	logic        restart_seen = 1'b0;
	logic [55:0] tbl [8] = '{56'h01_0040_0000_8102, 56'h06_c418_1234_8602,
		56'h06_0007_1234_8602, 56'h03_0000_0000_8302, 56'h07_0000_0000_8701,
		56'h08_0000_0003_8801, 56'h01_0050_0000_8102, 56'h05_0000_1234_8503};

	mdm_data_map DUT (.clock_i, .rst_i, .req_valid_i, .req_bcast_i, .req_func_i, .req_addr_i,
		.req_qty_i, .req_sub_i, .wr_valid_i, .wr_data_i, .bus_msg_i, .frame_err_i,
		.drive_state_i, .out_freq_i, .feedback_i, .closed_loop_i, .obj_err_valid_i,
		.obj_err_code_i, .par_avail_i, .par_ack_i, .par_rdata_i, .req_ready_o, .wr_ready_o,
		.rd_valid_o, .rd_data_o, .rsp_done_o, .rsp_send_o, .rsp_func_o, .rsp_exc_o,
		.drive_command_word_o, .bus_speed_reference_o, .store_eeprom_o, .dc_brake_req_o,
		.coast_req_o, .quick_stop_req_o, .freeze_req_o, .start_o, .par_req_o, .par_we_o,
		.par_num_o, .par_wdata_o, .par_index_o, .comm_restart_o);

	mdm_master m (.clock_i, .rdy_i(req_ready_o), .done_i(rsp_done_o), .send_i(rsp_send_o),
		.rdv_i(rd_valid_o), .rdd_i(rd_data_o), .preq_i(par_req_o), .pnum_i(par_num_o),
		.vld_o(req_valid_i), .bc_o(req_bcast_i), .fn_o(req_func_i), .ad_o(req_addr_i),
		.qt_o(req_qty_i), .sb_o(req_sub_i), .msg_o(bus_msg_i), .pack_o(par_ack_i),
		.prd_o(par_rdata_i));

	// restart is a one-cycle pulse, so keep a sticky copy
	always @(posedge clock_i)
		if (comm_restart_o)
			restart_seen <= 1'b1;

	initial
	begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end

	task automatic summarize();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// the 43 short requests of this test fit well inside this span
	initial
	begin
		#100us;
		miscompares++;
		summarize();
	end

	task automatic run(input logic b, input logic [7:0] f, input logic [15:0] a, q, s);
		m.xfer(b, f, a, q, s, d, sn, dn);
		#1;
		`CHK(dn, 1'b1)
	endtask

	initial
	begin
		{rst_i, par_avail_i, closed_loop_i, wr_valid_i, frame_err_i, obj_err_valid_i} = 6'h30;
		{drive_state_i, out_freq_i, feedback_i, wr_data_i, obj_err_code_i} = '0;
		v = 16'($urandom(32'hd1031763));
		repeat (2) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		#1;
		`CHK(drive_command_word_o, 16'h0000)
		`CHK({dc_brake_req_o, coast_req_o, quick_stop_req_o, freeze_req_o, start_o}, 5'h1e)
		v = 16'($urandom);
		run(0, 8'h06, 16'hc350, 16'h1, v);
		`CHK(drive_command_word_o, v)
		`CHK({rsp_func_o, rsp_exc_o, sn}, {8'h06, 8'h00, 1'b1})
		@(posedge clock_i);
		#1;
		`CHK({dc_brake_req_o, coast_req_o, quick_stop_req_o, freeze_req_o, start_o}, {~v[2], ~v[3], ~v[4], ~v[5], v[6]})
		run(1, 8'h06, 16'hc35a, 16'h1, ~v);
		`CHK({bus_speed_reference_o, sn}, {~v, 1'b0})
		$display("command test done");
		for (int k = 0; k < 2; k++)
		begin
			@(posedge clock_i);
			drive_state_i <= 16'($urandom);
			out_freq_i <= 16'($urandom);
			feedback_i <= 16'($urandom);
			closed_loop_i <= k[0];
			run(0, 8'h03, 16'hc418, 16'h1, 16'h0);
			`CHK(d, drive_state_i & ~16'h1070)
			run(0, 8'h03, 16'hc422, 16'h1, 16'h0);
			`CHK(d, k ? feedback_i : out_freq_i)
			run(0, 8'h01, 16'h0020, 16'h10, 16'h0);
			`CHK(d[0], drive_state_i[15])
		end
		$display("status test done");
		run(0, 8'h05, 16'h0040, 16'h1, 16'hff00);
		`CHK(store_eeprom_o, 1'b1)
		run(0, 8'h05, 16'h0006, 16'h1, 16'hff00);
		`CHK({drive_command_word_o[6], start_o}, 2'b11)
		foreach (tbl[i])
		begin
			run(0, tbl[i][55:48], tbl[i][47:32], 16'h2, tbl[i][31:16]);
			`CHK({rsp_func_o, rsp_exc_o, sn}, {tbl[i][15:0], 1'b1})
		end
		$display("exception test done");
		run(0, 8'h03, 16'h000a, 16'h1, 16'h0);
		`CHK(d, 16'h000a ^ 16'h3c3c)
		@(posedge clock_i);
		wr_valid_i <= 1'b1;
		wr_data_i <= v;
		run(0, 8'h0f, 16'h0010, 16'h10, 16'h0);
		`CHK(bus_speed_reference_o, {16{v[0]}})
		run(0, 8'h10, 16'h000a, 16'h1, 16'h0);
		`CHK({par_we_o, par_wdata_o, par_num_o, wr_ready_o}, {1'b1, v, 16'h000a, 1'b0})
		@(posedge clock_i);
		par_avail_i <= 1'b0;
		wr_valid_i <= 1'b0;
		run(0, 8'h03, 16'hc34f, 16'h1, 16'h0);
		`CHK({rsp_func_o, rsp_exc_o}, 16'h8301)
		run(0, 8'h06, 16'h0009, 16'h1, v ^ 16'h00ff);
		`CHK(par_index_o, v ^ 16'h00ff)
		@(posedge clock_i);
		obj_err_valid_i <= 1'b1;
		obj_err_code_i <= ~v;
		@(posedge clock_i);
		obj_err_valid_i <= 1'b0;
		run(0, 8'h03, 16'h0007, 16'h1, 16'h0);
		`CHK(d, ~v)
		$display("parameter test done");
		for (int k = 11; k < 15; k++)
		begin
			run(0, 8'h08, 16'h0, 16'h1, 16'(k));
			v = d;
			@(posedge clock_i);
			frame_err_i <= (k == 12);
			@(posedge clock_i);
			frame_err_i <= 1'b0;
			run(0, 8'h07, 16'h0, 16'h1, 16'h0);
			run(0, 8'h08, 16'h0, 16'h1, 16'(k));
			`CHK(16'(d - v), (k == 12 || k == 13) ? 16'h1 : 16'h2)
		end
		run(0, 8'h08, 16'h0, 16'h1, 16'h0002);
		`CHK(d, 16'h0001)
		run(0, 8'h08, 16'h0, 16'h1, 16'h0001);
		`CHK({restart_seen, d}, {1'b1, 16'h0000})
		run(0, 8'h08, 16'h0, 16'h1, 16'h000a);
		run(0, 8'h08, 16'h0, 16'h1, 16'h000d);
		`CHK(d, 16'h0000)
		run(0, 8'h11, 16'h0, 16'h1, 16'h0);
		`CHK(d, 16'h00a5)
		run(0, 8'h0b, 16'h0, 16'h1, 16'h0);
		v = d;
		run(0, 8'h0b, 16'h0, 16'h1, 16'h0);
		`CHK(16'(d - v), 16'h0001)
		$display("diagnostic test done");
		summarize();
	end
endmodule // test_modbus_drive_data_map
